//--- lcdc_pkg.sv
// Shared constants for the LCD driver serial command port
`default_nettype none
package lcdc_pkg;
    // Bus address and bit framing
    localparam logic [6:0] SLAVE_ADDR    = 7'h3F;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT   = 4'h7;
    // Display memory geometry
    localparam int         RAM_WORDS     = 22;
    localparam logic [4:0] RAM_FIRST     = 5'h00;
    localparam logic [4:0] RAM_LAST      = 5'h15;
    localparam int         SEG_BITS      = 176;
    // Command opcode fields
    localparam logic [2:0] OPC_POINTER   = 3'h0;
    localparam logic [2:0] OPC_MODE      = 3'h4;
    localparam logic [5:0] OPC_BLINK     = 6'h30;
    localparam logic [1:0] OPC_SUPPLY    = 2'h1;
    // Field positions inside the mode command
    localparam int         MODE_FRAME    = 4;
    localparam int         MODE_OSC      = 3;
    localparam int         MODE_DISP     = 2;
    localparam int         MODE_ZERO     = 1;
    localparam int         MODE_BIAS     = 0;
    // Field positions inside the supply command
    localparam int         SUP_SHARED    = 5;
    localparam int         SUP_ADJ       = 4;
    // Values after power-on
    localparam logic [7:0] MODE_RESET    = 8'h80;
    localparam logic [7:0] BLINK_RESET   = 8'hC0;
    localparam logic [7:0] SUPPLY_PRINT  = 8'h70;
    localparam logic [7:0] SUPPLY_RESET  = 8'h40;
    localparam logic [4:0] PTR_RESET     = 5'h00;
    // Oscillator cycles per blink period at the fastest rate
    localparam int         BLINK_DIV     = 16384;
    // Blink rate encodings
    localparam logic [1:0] BLINK_OFF     = 2'h0;
endpackage : lcdc_pkg
`default_nettype wire

//--- lcdc_top.sv
// Serial command port, display memory and mode registers of the LCD driver
`timescale 1ns/1ps
`default_nettype none
module lcdc_top #(
    parameter int BLINK_CYCLES = lcdc_pkg::BLINK_DIV
) (
    input  wire logic                          clock,
    input  wire logic                          reset,
    input  wire logic                          osc_clock,
    input  wire logic                          scl_i,
    input  wire logic                          sda_i,
    output logic                               sda_o,
    output logic                               sda_oe,
    output logic                               bias_select,
    output logic                               frame_rate_fast,
    output logic                               osc_enable,
    output logic                               display_on,
    output logic                               flash_rate_high,
    output logic                               flash_rate_low,
    output logic                               shared_pin_function,
    output logic                               internal_adjust_enable,
    output logic [3:0]                         supply_trim_code,
    output logic                               bias_voltage_follower,
    output logic [4:0]                         ram_pointer_bits,
    output logic [lcdc_pkg::SEG_BITS-1:0]      segment_data
);
    import lcdc_pkg::*;

    initial begin
        // The slowest half period must fit the 18-bit blink counter
        if (BLINK_CYCLES < 4 || BLINK_CYCLES > 131071) begin
            $error("BLINK_CYCLES out of range");
        end
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRX, ST_WACK, ST_TX, ST_TACK,
        ST_HOLD
    } lcdc_state_e;

    lcdc_state_e state_q;
    logic [2:0]  scl_q;
    logic [2:0]  sda_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        bus_start;
    logic        bus_stop;
    logic [3:0]  bit_cnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  tx_q;
    logic        read_q;
    logic        first_q;
    logic        discard_q;
    logic        adv_q;
    logic        ack_q;
    logic        sda_oe_q;
    logic        wbyte_done;
    logic        is_first;
    logic        is_data;
    logic        wack_end;
    logic        tack_end;
    logic        tx_load;
    logic [4:0]  ptr_q;
    logic [4:0]  ptr_next;
    logic [7:0]  mode_q;
    logic [7:0]  blink_q;
    logic [7:0]  supply_q;
    logic [7:0]  ram_q [RAM_WORDS];

    // Three flops on each pin; only the later stages feed edge logic
    always_ff @(posedge clock) begin
        if (reset) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], scl_i};
            sda_q <= {sda_q[1:0], sda_i};
        end
    end

    // Bus events seen on the synchronised copies
    assign scl_rise  = scl_q[1] & ~scl_q[2];
    assign scl_fall  = ~scl_q[1] & scl_q[2];
    assign bus_start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    assign bus_stop  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

    // Byte completion and phase ends used by the register blocks
    assign wbyte_done = (state_q == ST_WRX) && scl_fall
                        && (bit_cnt_q == BITS_PER_BYTE);
    assign is_first   = wbyte_done && first_q;
    assign is_data    = wbyte_done && !first_q && !discard_q;
    assign wack_end   = (state_q == ST_WACK) && scl_fall;
    assign tack_end   = (state_q == ST_TACK) && scl_fall && ack_q;
    assign tx_load    = ((state_q == ST_ADDR_ACK) && scl_fall && read_q)
                        || tack_end;

    assign ptr_next = (ptr_q == RAM_LAST) ? RAM_FIRST : ptr_q + 5'h01;

    // Protocol sequencer; START wins over everything but reset, STOP idles
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            tx_q      <= 8'h00;
            read_q    <= 1'b0;
            first_q   <= 1'b0;
            discard_q <= 1'b0;
            adv_q     <= 1'b0;
            ack_q     <= 1'b0;
            sda_oe_q  <= 1'b0;
        end else if (bus_start) begin
            state_q   <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            discard_q <= 1'b0;
            sda_oe_q  <= 1'b0;
        end else if (bus_stop) begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_q   <= {shift_q[6:0], sda_q[1]};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
                        bit_cnt_q <= 4'h0;
                        if (shift_q[7:1] == SLAVE_ADDR) begin
                            state_q  <= ST_ADDR_ACK;
                            read_q   <= shift_q[0];
                            first_q  <= ~shift_q[0];
                            sda_oe_q <= 1'b1;
                        end else begin
                            state_q <= ST_HOLD;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        // read starts at pointer, MSB first
                        if (read_q) begin
                            state_q  <= ST_TX;
                            tx_q     <= ram_q[ptr_q];
                            sda_oe_q <= ~ram_q[ptr_q][7];
                        end else begin
                            state_q  <= ST_WRX;
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
                ST_WRX: begin
                    if (scl_rise) begin
                        shift_q   <= {shift_q[6:0], sda_q[1]};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (wbyte_done) begin
                        state_q   <= ST_WACK;
                        bit_cnt_q <= 4'h0;
                        sda_oe_q  <= 1'b1;
                        first_q   <= 1'b0;
                        adv_q     <= is_data;
                        if (first_q && shift_q[7:5] != OPC_POINTER) begin
                            discard_q <= 1'b1;
                        end
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        state_q  <= ST_WRX;
                        sda_oe_q <= 1'b0;
                        adv_q    <= 1'b0;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == LAST_TX_BIT) begin
                            state_q  <= ST_TACK;
                            sda_oe_q <= 1'b0;
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            tx_q      <= {tx_q[6:0], 1'b0};
                            sda_oe_q  <= ~tx_q[6];
                        end
                    end
                end
                ST_TACK: begin
                    if (scl_rise) begin
                        ack_q <= ~sda_q[1];
                    end else if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        if (ack_q) begin
                            state_q  <= ST_TX;
                            tx_q     <= ram_q[ptr_next];
                            sda_oe_q <= ~ram_q[ptr_next][7];
                        end else begin
                            state_q <= ST_HOLD;
                        end
                    end
                end
                ST_IDLE, ST_HOLD: begin
                    sda_oe_q <= 1'b0;
                end
                default: begin
                    state_q  <= ST_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // RAM pointer: loaded by first byte, stepped after ack clocks
    always_ff @(posedge clock) begin
        if (reset) begin
            ptr_q <= PTR_RESET;
        end else if (is_first && shift_q[7:5] == OPC_POINTER) begin
            if (shift_q[4:0] <= RAM_LAST) begin
                ptr_q <= shift_q[4:0];
            end
        end else if (wack_end && adv_q) begin
            ptr_q <= ptr_next;
        end else if (tack_end) begin
            ptr_q <= ptr_next;
        end
    end

    // Display memory; cleared so the panel starts blank
    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < RAM_WORDS; i++) begin
                ram_q[i] <= 8'h00;
            end
        end else if (is_data) begin
            ram_q[ptr_q] <= shift_q;
        end
    end

    // Mode command register
    always_ff @(posedge clock) begin
        if (reset) begin
            mode_q <= MODE_RESET;
        end else if (is_first && shift_q[7:5] == OPC_MODE
                     && !shift_q[MODE_ZERO]) begin
            // mode decode, bit1 must be zero
            mode_q <= shift_q;
        end
    end

    // Blink command register; other low patterns are undefined
    always_ff @(posedge clock) begin
        if (reset) begin
            blink_q <= BLINK_RESET;
        end else if (is_first && shift_q[7:2] == OPC_BLINK) begin
            blink_q <= shift_q;
        end
    end

    // Supply command register
    always_ff @(posedge clock) begin
        if (reset) begin
            // adjust off, supply pin, not the printed default
            supply_q <= SUPPLY_RESET;
        end else if (is_first && shift_q[7:6] == OPC_SUPPLY) begin
            supply_q <= shift_q;
        end
    end

    // Open drain: data low, enable marks the pulled-down bits
    assign sda_o  = 1'b0;
    assign sda_oe = sda_oe_q;

    // bias select straight from mode bit
    assign bias_select      = mode_q[MODE_BIAS];
    assign frame_rate_fast  = mode_q[MODE_FRAME];
    assign osc_enable       = mode_q[MODE_OSC];
    assign display_on       = mode_q[MODE_OSC] & mode_q[MODE_DISP];
    assign flash_rate_high  = blink_q[1];
    assign flash_rate_low   = blink_q[0];
    assign ram_pointer_bits = ptr_q;

    assign shared_pin_function    = supply_q[SUP_SHARED];
    assign internal_adjust_enable = supply_q[SUP_ADJ];
    assign supply_trim_code       = supply_q[3:0];
    // follower off for 10 setting or zero trim
    assign bias_voltage_follower =
        !(supply_q[SUP_SHARED] && !supply_q[SUP_ADJ])
        && (supply_q[3:0] != 4'h0);

    // Oscillator domain: reset and settings cross by two flops
    logic [1:0]  osc_rst_q;
    logic [1:0]  osc_run_q;
    logic [1:0]  rate_hi_q;
    logic [1:0]  rate_lo_q;
    logic [17:0] blink_cnt_q;
    logic [17:0] blink_half;
    logic        blink_phase_q;

    always_ff @(posedge osc_clock) begin
        osc_rst_q <= {osc_rst_q[0], reset};
    end

    always_ff @(posedge osc_clock) begin
        if (osc_rst_q[1]) begin
            osc_run_q <= 2'h0;
            rate_hi_q <= 2'h0;
            rate_lo_q <= 2'h0;
        end else begin
            osc_run_q <= {osc_run_q[0], osc_enable};
            rate_hi_q <= {rate_hi_q[0], flash_rate_high};
            rate_lo_q <= {rate_lo_q[0], flash_rate_low};
        end
    end

    // Half blink period doubles for each slower rate step
    always_comb begin
        case ({rate_hi_q[1], rate_lo_q[1]})
            2'h1:    blink_half = 18'(BLINK_CYCLES / 2);
            2'h2:    blink_half = 18'(BLINK_CYCLES);
            2'h3:    blink_half = 18'(BLINK_CYCLES * 2);
            default: blink_half = 18'(BLINK_CYCLES / 2);
        endcase
    end

    // blink phase only runs with oscillator on and blink set
    always_ff @(posedge osc_clock) begin
        if (osc_rst_q[1]) begin
            blink_cnt_q   <= 18'h00000;
            blink_phase_q <= 1'b0;
        end else if (!osc_run_q[1]
                     || {rate_hi_q[1], rate_lo_q[1]} == BLINK_OFF) begin
            blink_cnt_q   <= 18'h00000;
            blink_phase_q <= 1'b0;
        end else if (blink_cnt_q >= blink_half - 18'h00001) begin
            blink_cnt_q   <= 18'h00000;
            blink_phase_q <= ~blink_phase_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 18'h00001;
        end
    end

    // Blink phase back into the bus clock, then gate the panel data
    logic [1:0] blank_q;
    always_ff @(posedge clock) begin
        if (reset) begin
            blank_q <= 2'h0;
        end else begin
            blank_q <= {blank_q[0], blink_phase_q};
        end
    end

    // byte n low nibble seg 2n, high nibble seg 2n+1
    always_ff @(posedge clock) begin
        if (reset) begin
            segment_data <= '0;
        end else begin
            for (int i = 0; i < RAM_WORDS; i++) begin
                segment_data[i*8 +: 8] <=
                    (display_on && !blank_q[1]) ? ram_q[i] : 8'h00;
            end
        end
    end
endmodule : lcdc_top
`default_nettype wire

//--- lcdc_checker.sv
// Concurrent checks on the LCD driver command port outputs
`timescale 1ns/1ps
`default_nettype none
module lcdc_checker #(
    parameter int BLINK_CYCLES = 16
) (
    input wire logic                     clock,
    input wire logic                     reset,
    input wire logic                     osc_clock,
    input wire logic                     scl_i,
    input wire logic                     sda_i,
    input wire logic                     sda_o,
    input wire logic                     sda_oe,
    input wire logic                     bias_select,
    input wire logic                     frame_rate_fast,
    input wire logic                     osc_enable,
    input wire logic                     display_on,
    input wire logic                     flash_rate_high,
    input wire logic                     flash_rate_low,
    input wire logic                     shared_pin_function,
    input wire logic                     internal_adjust_enable,
    input wire logic [3:0]               supply_trim_code,
    input wire logic                     bias_voltage_follower,
    input wire logic [4:0]               ram_pointer_bits,
    input wire logic [lcdc_pkg::SEG_BITS-1:0] segment_data
);
    import lcdc_pkg::*;
    // All checks run on the system clock; reset checks override the disable
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_reset_mode: assert property (disable iff (1'b0) reset |=>
        !bias_select && !frame_rate_fast && !osc_enable && !display_on)
        else $error("mode outputs not cleared by reset");
    a_reset_settings: assert property (disable iff (1'b0) reset |=>
        !shared_pin_function && !internal_adjust_enable &&
        supply_trim_code == 4'h0 && ram_pointer_bits == 5'h00 &&
        !flash_rate_high && !flash_rate_low)
        else $error("supply, pointer or blink not cleared by reset");
    a_reset_release: assert property (disable iff (1'b0) reset |=>
        !sda_oe) else $error("data line driven during reset");
    a_display_osc: assert property (display_on |-> osc_enable)
        else $error("display on with oscillator stopped");
    a_follower_trim: assert property (supply_trim_code == 4'h0
        |-> !bias_voltage_follower) else $error("follower on, trim zero");
    a_follower_shared: assert property (shared_pin_function &&
        !internal_adjust_enable |-> !bias_voltage_follower)
        else $error("follower on in segment mode without adjust");
    a_follower_on: assert property (supply_trim_code != 4'h0 &&
        !(shared_pin_function && !internal_adjust_enable)
        |-> bias_voltage_follower) else $error("follower off, trim set");
    a_pointer_range: assert property (ram_pointer_bits <= RAM_LAST)
        else $error("pointer beyond last display address");
    a_oe_steady_high: assert property ($rose(scl_i) |=>
        $stable(sda_oe)[*8]) else $error("data drive changed, clock high");
    a_blank_when_off: assert property (!display_on ##1 !display_on
        |-> segment_data == '0) else $error("segments lit, display off");

    // Main scenarios reached
    c_display: cover property ($rose(display_on));
    c_drive: cover property ($rose(sda_oe));
    c_wrap: cover property ($past(ram_pointer_bits) == RAM_LAST &&
        ram_pointer_bits == RAM_FIRST);
    c_follower: cover property ($rose(bias_voltage_follower));
endmodule : lcdc_checker
`default_nettype wire

//--- lcdc_host.sv
// Bus master model that clocks bytes into and out of the port
`timescale 1ns/1ps
`default_nettype none
module lcdc_host (
    input  wire logic clock,
    output var logic  scl,
    output var logic  sda_drv,
    input  wire logic sda_line
);
    localparam int QTR = 6; // Clocks per quarter bit, well above sync delay
    // Idle bus: both lines released, clock stands still
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic wait_q();
        repeat (QTR) @(negedge clock);
    endtask : wait_q
    // data moves only while the clock is low
    task automatic bit_x(input logic b, output logic s);
        scl = 1'b0;
        wait_q();
        sda_drv = b;
        wait_q();
        scl = 1'b1;
        wait_q();
        s = sda_line;
        wait_q();
    endtask : bit_x
    // start or repeated start: data falls with clock high
    task automatic start();
        scl = 1'b0;
        wait_q();
        sda_drv = 1'b1;
        wait_q();
        scl = 1'b1;
        wait_q();
        sda_drv = 1'b0;
        wait_q();
    endtask : start
    // stop: data rises with clock high, ends every transfer
    task automatic stop();
        scl = 1'b0;
        wait_q();
        sda_drv = 1'b0;
        wait_q();
        scl = 1'b1;
        wait_q();
        sda_drv = 1'b1;
        wait_q();
    endtask : stop
    // byte out MSB first, ninth clock reads the acknowledge
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(d[i], s);
        bit_x(1'b1, s);
        ack = ~s;
    endtask : put_byte
    // byte in MSB first, then ack to continue or nack to end
    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            d[i] = s;
        end
        bit_x(~ack, s);
    endtask : get_byte
endmodule : lcdc_host
`default_nettype wire

//--- tb.sv
// Self-checking bench for the LCD driver command port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lcdc_pkg::*;
    localparam int         BLINK = 16;
    localparam logic [7:0] ADW   = {SLAVE_ADDR, 1'b0};
    localparam logic [7:0] ADR   = {SLAVE_ADDR, 1'b1};
    logic clock, reset, osc_clock, scl, host_sda, sda_line, sda_o, sda_oe;
    logic bias, frame, osc, disp, fhi, flo, shared, adj, foll;
    logic [3:0]          trim;
    logic [4:0]          ptr;
    logic [SEG_BITS-1:0] seg;
    int                  err_total = 0;
    int                  check_count = 0;

    // Open-drain line with pull-up: low if either party pulls
    assign sda_line = host_sda & (sda_oe ? sda_o : 1'b1);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Oscillator, phase unrelated to the system clock
    initial begin
        osc_clock = 1'b0;
        #3;
        forever #32 osc_clock = ~osc_clock;
    end

    lcdc_host host (.clock(clock), .scl(scl), .sda_drv(host_sda),
        .sda_line(sda_line));
    lcdc_top #(.BLINK_CYCLES(BLINK)) DUT (.clock(clock), .reset(reset),
        .osc_clock(osc_clock), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .bias_select(bias),
        .frame_rate_fast(frame), .osc_enable(osc), .display_on(disp),
        .flash_rate_high(fhi), .flash_rate_low(flo),
        .shared_pin_function(shared), .internal_adjust_enable(adj),
        .supply_trim_code(trim), .bias_voltage_follower(foll),
        .ram_pointer_bits(ptr), .segment_data(seg));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // Whole write transfer; every byte expected acked or every one refused
    task automatic wr(input logic [7:0] q[$], input logic acked);
        logic a;
        host.start();
        foreach (q[i]) begin
            host.put_byte(q[i], a);
            chk("ack", {31'h0, acked}, {31'h0, a});
        end
        host.stop();
        repeat (8) @(negedge clock);
    endtask : wr

    task automatic t_reset();
        chk("mode", 32'h0, {frame, osc, disp, bias});
        chk("blink", 32'h0, {fhi, flo});
        chk("supply", 32'h0, {shared, adj, trim, foll});
        chk("ptr", 32'h0, ptr);
        chk("sda_o", 32'h0, sda_o);
    endtask : t_reset
    task automatic t_mode();
        logic [7:0] c[3] = '{8'h9F, 8'h85, 8'h88};
        logic [3:0] e[3] = '{4'hF, 4'h1, 4'h4};
        wr('{ADW, 8'h9D, 8'h05}, 1'b1);
        chk("mode", 32'hF, {frame, osc, disp, bias});
        chk("ptr", 32'h0, ptr);
        for (int i = 0; i < 3; i++) begin
            wr('{ADW, c[i]}, 1'b1);
            chk("mode", e[i], {frame, osc, disp, bias});
        end
    endtask : t_mode
    task automatic t_blink();
        for (int r = 0; r < 4; r++) begin
            wr('{ADW, 8'hC0 | 8'(r)}, 1'b1);
            chk("blink", r, {fhi, flo});
        end
        wr('{ADW, 8'hC5}, 1'b1);
        chk("blink", 32'h3, {fhi, flo});
    endtask : t_blink
    task automatic t_supply();
        logic [7:0] c[4] = '{8'h6A, 8'h55, 8'h50, 8'h7F};
        logic [6:0] e[4] = '{7'h54, 7'h2B, 7'h20, 7'h7F};
        for (int i = 0; i < 4; i++) begin
            wr('{ADW, c[i]}, 1'b1);
            chk("supply", e[i], {shared, adj, trim, foll});
        end
    endtask : t_supply
    task automatic t_ram();
        wr('{ADW, 8'h8C}, 1'b1);
        wr('{ADW, 8'hC0}, 1'b1);
        wr('{ADW, 8'h14, 8'hA5, 8'h3C, 8'h81}, 1'b1);
        chk("ptr", 32'h01, ptr);
        chk("seg20", 32'hA5, seg[8*20 +: 8]);
        chk("seg21", 32'h3C, seg[8*21 +: 8]);
        chk("seg0", 32'h81, seg[7:0]);
        wr('{ADW, 8'h17}, 1'b1);
        chk("ptr", 32'h01, ptr);
        wr('{8'h7C, 8'h03}, 1'b0);
        chk("ptr", 32'h01, ptr);
    endtask : t_ram
    task automatic t_read();
        logic       a;
        logic [7:0] d;
        host.start();
        host.put_byte(ADW, a);
        host.put_byte(8'h15, a);
        host.start();
        host.put_byte(ADR, a);
        chk("ack", 32'h1, a);
        host.get_byte(1'b1, d);
        chk("rd0", 32'h3C, d);
        host.get_byte(1'b0, d);
        chk("rd1", 32'h81, d);
        host.bit_x(1'b1, a);
        chk("released", 32'h1, a);
        host.stop();
        repeat (8) @(negedge clock);
        chk("ptr", 32'h00, ptr);
    endtask : t_read
    task automatic t_flash();
        int dark = 0;
        int lit = 0;
        wr('{ADW, 8'hC1}, 1'b1);
        repeat (600) begin
            @(negedge clock);
            if (seg === '0) dark++;
            else lit++;
        end
        chk("blank", 32'h1, dark > 0 && lit > 0);
        wr('{ADW, 8'hC0}, 1'b1);
    endtask : t_flash

    // Main sequence; synchronous reset also spans two rising oscillator edges
    initial begin
        reset = 1'b1;
        // host keeps the bus idle through the reset time
        repeat (25) @(negedge clock);
        reset = 1'b0;
        @(negedge clock);
        t_reset();
        t_mode();
        t_blink();
        t_supply();
        t_ram();
        t_read();
        t_flash();
        stop_test();
    end
    // Cuts a hang short
    initial begin
        repeat (60000) @(posedge clock);
        err_total++;
        $display("MISMATCH run expected end seen hang");
        stop_test();
    end
endmodule : tb
bind lcdc_top lcdc_checker #(.BLINK_CYCLES(BLINK_CYCLES)) chk_i (.clock,
    .reset, .osc_clock, .scl_i, .sda_i, .sda_o, .sda_oe, .bias_select,
    .frame_rate_fast, .osc_enable, .display_on, .flash_rate_high,
    .flash_rate_low, .shared_pin_function, .internal_adjust_enable,
    .supply_trim_code, .bias_voltage_follower, .ram_pointer_bits,
    .segment_data);
`default_nettype wire
